// *** verilog/bmmo_map.vh ***
// Constants for the bit-move / multiply / OR execution unit.
// Assumes inclusion by bare name from files under verilog/.
`ifndef BMMO_MAP_VH
`define BMMO_MAP_VH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define BMMO_OP_NOP       8'h00
`define BMMO_OP_MOV_C_BIT 8'hA3
`define BMMO_OP_MOV_BIT_C 8'h92
`define BMMO_OP_DP_LOAD   8'h90
`define BMMO_OP_CODE_DP   8'h93
`define BMMO_OP_CODE_PC   8'h83
`define BMMO_OP_XRD_RI    7'h71
`define BMMO_OP_XRD_DP    8'hE0
`define BMMO_OP_XWR_RI    7'h79
`define BMMO_OP_XWR_DP    8'hF0
`define BMMO_OP_MUL       8'hA4
`define BMMO_OP_OR_A_RN   5'h09
`define BMMO_OP_OR_A_DIR  8'h45
`define BMMO_OP_OR_A_IND  7'h23
`define BMMO_OP_OR_A_IMM  8'h44
`define BMMO_OP_OR_D_A    8'h42
`define BMMO_OP_OR_D_IMM  8'h43

// ----------------------------------------
// Operation classes
// ----------------------------------------
`define BMMO_CL_NOP     4'h0
`define BMMO_CL_C_BIT   4'h1
`define BMMO_CL_BIT_C   4'h2
`define BMMO_CL_DP_LOAD 4'h3
`define BMMO_CL_CODE_DP 4'h4
`define BMMO_CL_CODE_PC 4'h5
`define BMMO_CL_XRD_RI  4'h6
`define BMMO_CL_XRD_DP  4'h7
`define BMMO_CL_XWR_RI  4'h8
`define BMMO_CL_XWR_DP  4'h9
`define BMMO_CL_MUL     4'hA
`define BMMO_CL_OR_A    4'hB
`define BMMO_CL_OR_D    4'hC

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define BMMO_RST_BYTE   8'h00
`define BMMO_RST_WORD   16'h0000
`define BMMO_MUL_STEPS  2'h3
`endif

// *** verilog/bmmo_decode.v ***
// Opcode decoder: class, length in bytes and cycle count.
// Assumes an opcode held stable by the caller; purely combinational.
`timescale 1ns/1ns
`include "bmmo_map.vh"
module bmmo_decode (
   input  wire [7:0] op,
   output reg  [3:0] cls,
   output reg  [1:0] len,
   output reg  [2:0] ncyc,
   output reg        bad
);
   always @* begin
      cls  = `BMMO_CL_NOP;
      len  = 2'h1;
      ncyc = 3'h1;
      bad  = 1'b0;
      if (op == `BMMO_OP_NOP) begin
         cls = `BMMO_CL_NOP; // RULE14
      end else if (op == `BMMO_OP_MOV_C_BIT) begin
         cls = `BMMO_CL_C_BIT; len = 2'h2; // RULE2
      end else if (op == `BMMO_OP_MOV_BIT_C) begin
         cls = `BMMO_CL_BIT_C; len = 2'h2; ncyc = 3'h2; // RULE3
      end else if (op == `BMMO_OP_DP_LOAD) begin
         cls = `BMMO_CL_DP_LOAD; len = 2'h3; ncyc = 3'h2;
      end else if (op == `BMMO_OP_CODE_DP) begin
         cls = `BMMO_CL_CODE_DP; ncyc = 3'h2;
      end else if (op == `BMMO_OP_CODE_PC) begin
         cls = `BMMO_CL_CODE_PC; ncyc = 3'h2; // RULE6
      end else if (op[7:1] == `BMMO_OP_XRD_RI) begin
         cls = `BMMO_CL_XRD_RI; ncyc = 3'h2; // RULE11
      end else if (op == `BMMO_OP_XRD_DP) begin
         cls = `BMMO_CL_XRD_DP; ncyc = 3'h2; // RULE11
      end else if (op[7:1] == `BMMO_OP_XWR_RI) begin
         cls = `BMMO_CL_XWR_RI; ncyc = 3'h2; // RULE11
      end else if (op == `BMMO_OP_XWR_DP) begin
         cls = `BMMO_CL_XWR_DP; ncyc = 3'h2; // RULE11
      end else if (op == `BMMO_OP_MUL) begin
         cls = `BMMO_CL_MUL; ncyc = 3'h4; // RULE12
      end else if (op[7:3] == `BMMO_OP_OR_A_RN || op[7:1] == `BMMO_OP_OR_A_IND) begin
         cls = `BMMO_CL_OR_A; // RULE18
      end else if (op == `BMMO_OP_OR_A_DIR || op == `BMMO_OP_OR_A_IMM) begin
         cls = `BMMO_CL_OR_A; len = 2'h2; // RULE18
      end else if (op == `BMMO_OP_OR_D_A) begin
         cls = `BMMO_CL_OR_D; len = 2'h2; // RULE16
      end else if (op == `BMMO_OP_OR_D_IMM) begin
         cls = `BMMO_CL_OR_D; len = 2'h3; ncyc = 3'h2; // RULE16
      end else begin
         bad = 1'b1;
      end
   end
endmodule

// *** verilog/bmmo_mul.v ***
// Unsigned 8x8 multiplier, two multiplier bits per clock.
// Assumes start is a one-cycle pulse; product is complete three
// edges after the start edge and holds until the next start.
`timescale 1ns/1ns
`include "bmmo_map.vh"
module bmmo_mul (
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire        start,
   input  wire [7:0]  a_in,
   input  wire [7:0]  b_in,
   output wire [15:0] product
);
   reg [7:0]  a_reg;
   reg [7:0]  b_reg;
   reg [15:0] prod_reg;
   reg [1:0]  step_reg;
   reg        run_reg;

   function [15:0] partial;
      input [7:0] a;
      input [1:0] bits;
      input [1:0] step;
      begin
         partial = ({8'h00, a} * {14'h0000, bits}) << {step, 1'b0};
      end
   endfunction

   assign product = prod_reg;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         a_reg    <= `BMMO_RST_BYTE;
         b_reg    <= `BMMO_RST_BYTE;
         prod_reg <= `BMMO_RST_WORD;
         step_reg <= 2'h0;
         run_reg  <= 1'b0;
      end else if (start) begin
         a_reg    <= a_in;
         b_reg    <= b_in;
         prod_reg <= partial(a_in, b_in[1:0], 2'h0);
         step_reg <= 2'h1;
         run_reg  <= 1'b1;
      end else if (run_reg) begin
         prod_reg <= prod_reg + partial(a_reg, b_reg[{step_reg, 1'b0} +: 2], step_reg);
         step_reg <= step_reg + 2'h1;
         run_reg  <= (step_reg != `BMMO_MUL_STEPS);
      end
   end
endmodule

// *** verilog/bmmo_exec.v ***
// Execution unit for bit moves, pointer load, code reads, external
// data moves, unsigned multiply, no-operation and byte OR.
// Assumes the fetch logic presents all instruction bytes and the
// needed operand values together with instr_valid, and that the
// surrounding core performs direct and bit writes from the pulses.
//
// Behaviour
// RULE1: bit moves copy between carry and a direct bit, nothing else changes.
// RULE2: opcode A3 plus bit address loads carry; two bytes, one cycle.
// RULE3: opcode 92 plus bit address stores carry; two bytes, two cycles.
// RULE4: pointer load puts byte two in high byte, byte three in low.
// RULE5: code read address is accumulator plus 16-bit base, full carry.
// RULE6: with program counter base, advance it first; opcode 83, two cycles.
// RULE7: code read through data pointer leaves the pointer unchanged.
// RULE8: indirect external moves use R0 or R1 as 8-bit multiplexed address.
// RULE9: pointer external moves drive high byte out, low byte multiplexed.
// RULE10: high port latch keeps its value while pointer high byte is shown.
// RULE11: four external moves, one byte and two cycles each.
// RULE12: opcode A4 multiplies accumulator by B in four cycles.
// RULE13: multiply sets overflow above 255, always clears carry.
// RULE14: opcode 00 only advances the program counter.
// RULE15: byte OR writes the bitwise OR to the destination, flags kept.
// RULE16: six OR forms: four into accumulator, two into a direct byte.
// RULE17: OR into a port reads the output latch, not the pins.
// RULE18: OR forms 48-4F, 45 and 46-47 into accumulator take one cycle.
`timescale 1ns/1ns
`include "bmmo_map.vh"
module bmmo_exec (
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire        instr_valid,
   input  wire [7:0]  instr_op,
   input  wire [7:0]  instr_byte2,
   input  wire [7:0]  instr_byte3,
   input  wire [7:0]  bank_register_val,
   input  wire [7:0]  indirect_pointer_reg0,
   input  wire [7:0]  indirect_pointer_reg1,
   input  wire [7:0]  indirect_data_val,
   input  wire [7:0]  direct_pin_val,
   input  wire [7:0]  direct_latch_val,
   input  wire        bit_val,
   input  wire [7:0]  code_data_in,
   input  wire [7:0]  ext_data_in,
   input  wire [7:0]  high_port_latch,
   output reg         busy_reg,
   output reg         done_reg,
   output reg         bad_op_reg,
   output reg  [7:0]  acc_reg,
   output reg  [7:0]  b_reg,
   output reg  [7:0]  pointer_high_byte_reg,
   output reg  [7:0]  pointer_low_byte_reg,
   output reg  [15:0] program_counter_reg,
   output reg         carry_reg,
   output reg         overflow_flag_reg,
   output reg         dir_wr_en_reg,
   output reg  [7:0]  dir_wr_addr_reg,
   output reg  [7:0]  dir_wr_data_reg,
   output reg         bit_wr_en_reg,
   output reg  [7:0]  bit_wr_addr_reg,
   output reg         bit_wr_data_reg,
   output reg         code_rd_en_reg,
   output reg  [15:0] code_addr_reg,
   output reg  [7:0]  low_addr_data_port_out_reg,
   output reg         low_addr_data_port_oe_reg,
   output reg  [7:0]  high_addr_port_out_reg,
   output reg         ext_ale_reg,
   output reg         ext_rd_n_reg,
   output reg         ext_wr_n_reg
);

   // ----------------------------------------
   // States and working registers
   // ----------------------------------------
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_RUN  = 2'b10;

   reg [1:0] state_reg;
   reg [7:0] op_reg;
   reg [7:0] byte2_reg;
   reg [7:0] byte3_reg;
   reg [3:0] cls_reg;
   reg [1:0] len_reg;
   reg [2:0] ncyc_reg;
   reg [2:0] cyc_reg;
   reg [7:0] src_reg;
   reg [7:0] dst_reg;
   reg       bit_src_reg;

   wire [3:0]  dec_cls;
   wire [1:0]  dec_len;
   wire [2:0]  dec_ncyc;
   wire        dec_bad;
   wire [15:0] mul_product;
   wire        accept;
   wire        mul_start;
   wire        last_cyc;
   wire        dp_xfer_start;
   wire        dp_xfer_run;
   wire [15:0] pc_next_instr;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function is_ext;
      input [3:0] cls;
      begin
         is_ext = (cls == `BMMO_CL_XRD_RI) || (cls == `BMMO_CL_XRD_DP) ||
                  (cls == `BMMO_CL_XWR_RI) || (cls == `BMMO_CL_XWR_DP);
      end
   endfunction

   function is_ext_dp;
      input [3:0] cls;
      begin
         is_ext_dp = (cls == `BMMO_CL_XRD_DP) || (cls == `BMMO_CL_XWR_DP);
      end
   endfunction

   function is_ext_rd;
      input [3:0] cls;
      begin
         is_ext_rd = (cls == `BMMO_CL_XRD_RI) || (cls == `BMMO_CL_XRD_DP);
      end
   endfunction

   // Source operand of an OR into the accumulator
   function [7:0] or_src;
      input [7:0] op;
      input [7:0] rn;
      input [7:0] dir;
      input [7:0] ind;
      input [7:0] imm;
      begin
         if (op[3])
            or_src = rn;
         else if (op[1])
            or_src = ind;
         else if (op[0])
            or_src = dir;
         else
            or_src = imm;
      end
   endfunction

   // ----------------------------------------
   // Submodules
   // ----------------------------------------
   bmmo_decode u_decode (
      .op   (instr_op),
      .cls  (dec_cls),
      .len  (dec_len),
      .ncyc (dec_ncyc),
      .bad  (dec_bad)
   );

   bmmo_mul u_mul (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .start    (mul_start),
      .a_in     (acc_reg),
      .b_in     (b_reg),
      .product  (mul_product)
   );

   assign accept = (state_reg == ST_IDLE) && instr_valid;
   assign mul_start = accept && (dec_cls == `BMMO_CL_MUL);
   assign last_cyc = (cyc_reg == ncyc_reg - 3'h1);
   assign dp_xfer_start = accept && is_ext_dp(dec_cls);
   assign dp_xfer_run = (state_reg == ST_RUN) && is_ext_dp(cls_reg) && !last_cyc;
   assign pc_next_instr = program_counter_reg + {14'h0000, len_reg};

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         op_reg <= `BMMO_RST_BYTE;
         byte2_reg <= `BMMO_RST_BYTE;
         byte3_reg <= `BMMO_RST_BYTE;
         cls_reg <= `BMMO_CL_NOP;
         len_reg <= 2'h1;
         ncyc_reg <= 3'h1;
         cyc_reg <= 3'h0;
         src_reg <= `BMMO_RST_BYTE;
         dst_reg <= `BMMO_RST_BYTE;
         bit_src_reg <= 1'b0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         bad_op_reg <= 1'b0;
         acc_reg <= `BMMO_RST_BYTE;
         b_reg <= `BMMO_RST_BYTE;
         pointer_high_byte_reg <= `BMMO_RST_BYTE;
         pointer_low_byte_reg <= `BMMO_RST_BYTE;
         program_counter_reg <= `BMMO_RST_WORD;
         carry_reg <= 1'b0;
         overflow_flag_reg <= 1'b0;
         dir_wr_en_reg <= 1'b0;
         dir_wr_addr_reg <= `BMMO_RST_BYTE;
         dir_wr_data_reg <= `BMMO_RST_BYTE;
         bit_wr_en_reg <= 1'b0;
         bit_wr_addr_reg <= `BMMO_RST_BYTE;
         bit_wr_data_reg <= 1'b0;
         code_rd_en_reg <= 1'b0;
         code_addr_reg <= `BMMO_RST_WORD;
         low_addr_data_port_out_reg <= `BMMO_RST_BYTE;
         low_addr_data_port_oe_reg <= 1'b0;
         high_addr_port_out_reg <= `BMMO_RST_BYTE;
         ext_ale_reg <= 1'b0;
         ext_rd_n_reg <= 1'b1;
         ext_wr_n_reg <= 1'b1;
      end else begin
         done_reg       <= 1'b0;
         dir_wr_en_reg  <= 1'b0;
         bit_wr_en_reg  <= 1'b0;
         code_rd_en_reg <= 1'b0;
         ext_ale_reg    <= 1'b0;
         // Port latch is never written here, only bypassed
         if (dp_xfer_start || dp_xfer_run)
            high_addr_port_out_reg <= pointer_high_byte_reg; // RULE9 RULE10
         else
            high_addr_port_out_reg <= high_port_latch; // RULE10
         case (state_reg)
            ST_IDLE: begin
               if (instr_valid) begin
                  state_reg   <= ST_RUN;
                  busy_reg    <= 1'b1;
                  op_reg      <= instr_op;
                  byte2_reg   <= instr_byte2;
                  byte3_reg   <= instr_byte3;
                  cls_reg     <= dec_cls;
                  len_reg     <= dec_len;
                  ncyc_reg    <= dec_ncyc;
                  cyc_reg     <= 3'h0;
                  bad_op_reg  <= dec_bad;
                  bit_src_reg <= bit_val;
                  src_reg     <= or_src(instr_op, bank_register_val, direct_pin_val,
                                        indirect_data_val, instr_byte2); // RULE16
                  // Read-modify-write of a port must see the latch
                  dst_reg     <= direct_latch_val; // RULE17
                  if (dec_cls == `BMMO_CL_CODE_DP) begin
                     code_rd_en_reg <= 1'b1;
                     code_addr_reg  <= {pointer_high_byte_reg, pointer_low_byte_reg} +
                                       {8'h00, acc_reg}; // RULE5 RULE7
                  end
                  if (dec_cls == `BMMO_CL_CODE_PC) begin
                     code_rd_en_reg <= 1'b1;
                     code_addr_reg  <= program_counter_reg + 16'h0001 +
                                       {8'h00, acc_reg}; // RULE5 RULE6
                  end
                  if (is_ext(dec_cls)) begin
                     ext_ale_reg               <= 1'b1;
                     low_addr_data_port_oe_reg <= 1'b1;
                     if (is_ext_dp(dec_cls))
                        low_addr_data_port_out_reg <= pointer_low_byte_reg; // RULE9
                     else if (instr_op[0])
                        low_addr_data_port_out_reg <= indirect_pointer_reg1; // RULE8
                     else
                        low_addr_data_port_out_reg <= indirect_pointer_reg0; // RULE8
                  end
               end
            end
            ST_RUN: begin
               cyc_reg <= cyc_reg + 3'h1;
               // Data phase of an external move follows the address phase
               if (is_ext(cls_reg) && (cyc_reg == 3'h0)) begin
                  if (is_ext_rd(cls_reg)) begin
                     low_addr_data_port_oe_reg <= 1'b0;
                     ext_rd_n_reg              <= 1'b0;
                  end else begin
                     low_addr_data_port_out_reg <= acc_reg;
                     ext_wr_n_reg               <= 1'b0;
                  end
               end
               if (last_cyc) begin
                  state_reg <= ST_IDLE;
                  busy_reg <= 1'b0;
                  done_reg <= 1'b1;
                  ext_rd_n_reg <= 1'b1;
                  ext_wr_n_reg <= 1'b1;
                  low_addr_data_port_oe_reg <= 1'b0;
                  // Relative code base is the following instruction
                  program_counter_reg <= pc_next_instr; // RULE14 RULE6
                  case (cls_reg)
                     `BMMO_CL_NOP: begin
                     end
                     `BMMO_CL_C_BIT: begin
                        carry_reg <= bit_src_reg; // RULE1 RULE2
                     end
                     `BMMO_CL_BIT_C: begin
                        bit_wr_en_reg   <= 1'b1; // RULE1 RULE3
                        bit_wr_addr_reg <= byte2_reg;
                        bit_wr_data_reg <= carry_reg;
                     end
                     `BMMO_CL_DP_LOAD: begin
                        pointer_high_byte_reg <= byte2_reg; // RULE4
                        pointer_low_byte_reg  <= byte3_reg; // RULE4
                     end
                     `BMMO_CL_CODE_DP, `BMMO_CL_CODE_PC: begin
                        acc_reg <= code_data_in; // RULE5
                     end
                     `BMMO_CL_XRD_RI, `BMMO_CL_XRD_DP: begin
                        acc_reg <= ext_data_in; // RULE11
                     end
                     `BMMO_CL_XWR_RI, `BMMO_CL_XWR_DP: begin
                     end
                     `BMMO_CL_MUL: begin
                        acc_reg <= mul_product[7:0]; // RULE12
                        b_reg <= mul_product[15:8]; // RULE12
                        overflow_flag_reg <= (mul_product[15:8] != 8'h00); // RULE13
                        carry_reg <= 1'b0; // RULE13
                     end
                     `BMMO_CL_OR_A: begin
                        acc_reg <= acc_reg | src_reg; // RULE15 RULE18
                     end
                     `BMMO_CL_OR_D: begin
                        dir_wr_en_reg   <= 1'b1; // RULE15 RULE16
                        dir_wr_addr_reg <= byte2_reg;
                        if (op_reg[0])
                           dir_wr_data_reg <= dst_reg | byte3_reg; // RULE17
                        else
                           dir_wr_data_reg <= dst_reg | acc_reg; // RULE17
                     end
                     default: begin
                     end
                  endcase
               end
            end
            default: begin
               state_reg <= ST_IDLE;
               busy_reg  <= 1'b0;
            end
         endcase
      end
   end

endmodule

// *** dv/bmmo_exec_sva.sv ***
// Concurrent checks on the execution unit ports.
// Assumes one clock domain; bound to every bmmo_exec instance.
`timescale 1ns/1ns
module bmmo_exec_sva (
   input logic        core_clk, rst_n, instr_valid, bit_val,
   input logic [7:0]  instr_op, instr_byte2, bank_register_val, direct_latch_val,
   input logic [7:0]  indirect_pointer_reg0, indirect_pointer_reg1, high_port_latch,
   input logic        busy_reg, done_reg, carry_reg, overflow_flag_reg, dir_wr_en_reg,
   input logic        bit_wr_en_reg, bit_wr_data_reg, code_rd_en_reg, ext_ale_reg,
   input logic        low_addr_data_port_oe_reg, ext_wr_n_reg,
   input logic [7:0]  acc_reg, b_reg, pointer_high_byte_reg, pointer_low_byte_reg,
   input logic [7:0]  dir_wr_data_reg, low_addr_data_port_out_reg, high_addr_port_out_reg,
   input logic [15:0] program_counter_reg, code_addr_reg
);
   wire take = instr_valid && !busy_reg;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_mul_len: assert property (p_mul_len) else $error("mul length");
   property p_mul_len;
      take && instr_op == 8'hA4 |=> busy_reg [*4] ##1 (done_reg && !busy_reg);
   endproperty
   a_mul_res: assert property (p_mul_res) else $error("mul result");
   property p_mul_res;
      take && instr_op == 8'hA4 |-> ##5 {b_reg, acc_reg} == $past(acc_reg, 5) * $past(b_reg, 5)
         && !carry_reg && overflow_flag_reg == (b_reg != 8'h00);
   endproperty
   a_nop: assert property (p_nop) else $error("nop state");
   property p_nop;
      take && instr_op == 8'h00 |=> ##1 done_reg && $stable(acc_reg) && $stable(carry_reg)
         && program_counter_reg == $past(program_counter_reg) + 16'h0001;
   endproperty
   a_c_bit: assert property (p_c_bit) else $error("carry load wrong");
   property p_c_bit;
      take && instr_op == 8'hA3 |=> ##1 done_reg && carry_reg == $past(bit_val, 2);
   endproperty
   a_bit_c: assert property (p_bit_c) else $error("carry store wrong");
   property p_bit_c;
      take && instr_op == 8'h92 |=> !bit_wr_en_reg ##2
         (bit_wr_en_reg && done_reg && bit_wr_data_reg == $past(carry_reg, 3));
   endproperty
   a_code_pc: assert property (p_code_pc) else $error("code address wrong");
   property p_code_pc;
      take && instr_op == 8'h83 |=> code_rd_en_reg && code_addr_reg ==
         $past(program_counter_reg) + 16'h0001 + {8'h00, $past(acc_reg)};
   endproperty
   a_code_dp: assert property (p_code_dp) else $error("code dp read");
   property p_code_dp;
      take && instr_op == 8'h93 |=> code_rd_en_reg && code_addr_reg ==
         {$past(pointer_high_byte_reg), $past(pointer_low_byte_reg)} + {8'h00, $past(acc_reg)}
         ##1 ($stable(pointer_high_byte_reg) && $stable(pointer_low_byte_reg)) [*2];
   endproperty
   a_xdp: assert property (p_xdp) else $error("dp address");
   property p_xdp;
      take && (instr_op == 8'hE0 || instr_op == 8'hF0) |=> ext_ale_reg
         && low_addr_data_port_oe_reg && low_addr_data_port_out_reg == $past(pointer_low_byte_reg)
         && high_addr_port_out_reg == $past(pointer_high_byte_reg);
   endproperty
   a_xri: assert property (p_xri) else $error("ri address");
   property p_xri;
      take && instr_op[7:5] == 3'h7 && instr_op[3:1] == 3'h1 |=> ext_ale_reg
         && high_addr_port_out_reg == $past(high_port_latch) && low_addr_data_port_out_reg ==
         ($past(instr_op[0]) ? $past(indirect_pointer_reg1) : $past(indirect_pointer_reg0));
   endproperty
   a_xwr: assert property (p_xwr) else $error("xwrite");
   property p_xwr;
      take && instr_op[7:4] == 4'hF && instr_op[2:1] == 2'h0 |=> ##1 !ext_wr_n_reg
         && low_addr_data_port_oe_reg && low_addr_data_port_out_reg == acc_reg
         ##1 ext_wr_n_reg && done_reg;
   endproperty
   a_or_d: assert property (p_or_d) else $error("or direct");
   property p_or_d;
      take && instr_op == 8'h42 |=> ##1 dir_wr_en_reg
         && dir_wr_data_reg == ($past(direct_latch_val, 2) | $past(acc_reg, 2));
   endproperty
   a_or_rn: assert property (p_or_rn) else $error("or register");
   property p_or_rn;
      take && instr_op[7:3] == 5'h09 |=> ##1 done_reg
         && acc_reg == ($past(acc_reg, 2) | $past(bank_register_val, 2));
   endproperty
endmodule
bind bmmo_exec bmmo_exec_sva bmmo_exec_sva_i (.*);

// *** dv/bmmo_xram.sv ***
// External data memory on the multiplexed low port and high port.
// Assumes the address is latched on the strobe, read data taken at edge.
`timescale 1ns/1ns
module bmmo_xram (
   input  wire logic       core_clk,
   input  wire logic       ext_ale_reg,
   input  wire logic [7:0] low_addr_data_port_out_reg,
   input  wire logic [7:0] high_addr_port_out_reg,
   input  wire logic       ext_rd_n_reg,
   input  wire logic       ext_wr_n_reg,
   output wire logic [7:0] ext_data_in
);
   logic [7:0]  mem [0:65535];
   logic [15:0] addr;
   logic [7:0]  last;
   initial begin
      addr = 16'h0000;
      last = 8'h00;
      for (int i = 0; i < 65536; i++)
         mem[i] = i[7:0] ^ i[15:8] ^ 8'h5A;
   end
   always @(posedge core_clk) begin
      if (ext_ale_reg)
         addr <= {high_addr_port_out_reg, low_addr_data_port_out_reg};
      if (!ext_wr_n_reg)
         mem[addr] <= low_addr_data_port_out_reg;
      if (!ext_rd_n_reg)
         last <= mem[addr];
   end
   // Released bus shows inverted data so a stale sample cannot match
   assign ext_data_in = ext_rd_n_reg ? ~last : mem[addr];
endmodule

// *** dv/tb_bmmo_exec.sv ***
// Directed bench for the execution unit with an external memory model.
// Assumes operands held from offer until done; inputs move at falling edge.
`timescale 1ns/1ns
module tb_bmmo_exec;
   logic        core_clk, rst_n, instr_valid, bit_val;
   logic [7:0]  instr_op, instr_byte2, instr_byte3, bank_register_val, indirect_data_val;
   logic [7:0]  indirect_pointer_reg0, indirect_pointer_reg1, direct_pin_val;
   logic [7:0]  direct_latch_val, code_data_in, ext_data_in, high_port_latch;
   logic        busy_reg, done_reg, bad_op_reg, carry_reg, overflow_flag_reg, dir_wr_en_reg;
   logic        bit_wr_en_reg, bit_wr_data_reg, code_rd_en_reg, low_addr_data_port_oe_reg;
   logic        ext_ale_reg, ext_rd_n_reg, ext_wr_n_reg;
   logic [7:0]  acc_reg, b_reg, pointer_high_byte_reg, pointer_low_byte_reg, dir_wr_addr_reg;
   logic [7:0]  dir_wr_data_reg, bit_wr_addr_reg, low_addr_data_port_out_reg;
   logic [7:0]  high_addr_port_out_reg;
   logic [15:0] program_counter_reg, code_addr_reg, pc_m, exp16;
   logic [7:0]  orop [5] = '{8'h4D, 8'h45, 8'h46, 8'h47, 8'h44};
   logic [7:0]  orexp [5] = '{8'h01, 8'h03, 8'h07, 8'h07, 8'h0F};
   int          error_cnt, n_checks, cyc;

   bmmo_exec bmmo_exec_i (.*);
   bmmo_xram bmmo_xram_i (.*);

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         end_sim();
      end
   end

   task automatic chk(input logic [23:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Offer one instruction, wait for done, check length through the pc
   task automatic exec(input logic [7:0] op, b2, b3, input int len);
      int n;
      {instr_op, instr_byte2, instr_byte3, instr_valid} = {op, b2, b3, 1'b1};
      @(negedge core_clk);
      instr_valid = 1'b0;
      n = 0;
      while (done_reg !== 1'b1 && n < 8) begin
         @(negedge core_clk);
         n++;
      end
      pc_m = pc_m + len[15:0];
      chk(done_reg, 1'b1);
      chk(program_counter_reg, pc_m);
   endtask

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      {rst_n, instr_valid, bit_val, instr_op, instr_byte2, instr_byte3} = '0;
      {indirect_pointer_reg0, indirect_pointer_reg1, code_data_in} = '0;
      bank_register_val = 8'h01;
      direct_pin_val = 8'h02;
      direct_latch_val = 8'h80;
      indirect_data_val = 8'h04;
      high_port_latch = 8'h77;
      pc_m = 16'h0000;
      repeat (16) @(negedge core_clk);
      rst_n = 1'b1;
      exec(8'h00, 8'h00, 8'h00, 1);
      chk(acc_reg, 8'h00);
      exec(8'hA5, 8'h00, 8'h00, 1);
      chk(bad_op_reg, 1'b1);
      bit_val = 1'b1;
      exec(8'hA3, 8'h33, 8'h00, 2);
      chk(carry_reg, 1'b1);
      exec(8'h92, 8'h4B, 8'h00, 2);
      chk({bit_wr_en_reg, bit_wr_data_reg, bit_wr_addr_reg}, 10'h34B);
      $display("test bit moves ended");
      exec(8'h90, 8'h12, 8'hF0, 3);
      chk({pointer_high_byte_reg, pointer_low_byte_reg}, 16'h12F0);
      code_data_in = 8'hF7;
      exec(8'h93, 8'h00, 8'h00, 1);
      chk(code_addr_reg, 16'h12F0);
      code_data_in = 8'hC3;
      exec(8'h93, 8'h00, 8'h00, 1);
      chk(code_addr_reg, 16'h13E7);
      chk({pointer_high_byte_reg, pointer_low_byte_reg}, 16'h12F0);
      code_data_in = 8'h40;
      exp16 = pc_m + 16'h00C4;
      exec(8'h83, 8'h00, 8'h00, 1);
      chk(code_addr_reg, exp16);
      chk(acc_reg, 8'h40);
      exec(8'hA4, 8'h00, 8'h00, 1);
      chk({b_reg, acc_reg, carry_reg, overflow_flag_reg}, 18'h0);
      $display("test pointer code multiply ended");
      for (int k = 0; k < 5; k++) begin
         exec(orop[k], 8'h08, 8'h00, (k == 1 || k == 4) ? 2 : 1);
         chk(acc_reg, orexp[k]);
      end
      exec(8'h42, 8'h90, 8'h00, 2);
      chk({dir_wr_en_reg, dir_wr_addr_reg, dir_wr_data_reg}, 17'h1908F);
      exec(8'h43, 8'hA0, 8'h30, 3);
      chk({dir_wr_en_reg, dir_wr_addr_reg, dir_wr_data_reg}, 17'h1A0B0);
      $display("test byte or ended");
      exec(8'hF0, 8'h00, 8'h00, 1);
      exec(8'h44, 8'h30, 8'h00, 2);
      exec(8'hE0, 8'h00, 8'h00, 1);
      chk(acc_reg, 8'h0F);
      @(negedge core_clk);
      chk(high_addr_port_out_reg, 8'h77);
      high_port_latch = 8'h12;
      indirect_pointer_reg0 = 8'hF0;
      indirect_pointer_reg1 = 8'h55;
      exec(8'hE2, 8'h00, 8'h00, 1);
      chk(acc_reg, 8'h0F);
      exec(8'hE3, 8'h00, 8'h00, 1);
      chk(acc_reg, 8'h1D);
      exec(8'h44, 8'h20, 8'h00, 2);
      exec(8'hF3, 8'h00, 8'h00, 1);
      exec(8'h44, 8'h40, 8'h00, 2);
      exec(8'hE3, 8'h00, 8'h00, 1);
      chk(acc_reg, 8'h3D);
      $display("test external moves ended");
      end_sim();
   end
endmodule
